/* rtl/iohc_pkg.sv */
// constants for the internal-oscillator halt standby controller
// assumes a single 200 MHz clock and a synchronous active-high reset
package iohc_pkg;
    // count clock selections seen by the gating logic
    localparam logic [1:0] TMR16_CLK_WATCH_INT = 2'h1;
    localparam logic [1:0] TMR8_CLK_EXT_INPUT = 2'h1;
    localparam logic [1:0] TMR8_CLK_T16_CMP = 2'h2;
    localparam logic [1:0] CMPT_CLK_OSC_DIV2048 = 2'h3;
    localparam logic [1:0] WT_CLK_SUBCLOCK = 2'h1;
    // number of timer8 units gated here
    localparam int TIMER8_UNITS = 2;
    // priority level width of the interrupt controller
    localparam int PRIO_W = 3;
    // operating modes of the clock system
    typedef enum logic [1:0] {
        IOHC_NORMAL,
        IOHC_OSC_RUN,
        IOHC_OSC_HALT
    } iohc_mode_t;
    // what the cpu does after a wake-up
    localparam logic [1:0] RESUME_NONE = 2'h0;
    localparam logic [1:0] RESUME_NEXT = 2'h1;
    localparam logic [1:0] RESUME_BRANCH = 2'h2;
endpackage

/* rtl/iohc_ctrl.sv */
// halt standby controller for internal-oscillator clock operation
// assumes cpu pulses halt_exec_i and interrupt controller reports requests
// Summary of operation
// - halt instruction in oscillator mode enters halt
// - cpu clock gated; internal oscillator keeps running
// - execution stops, ram contents held
// - main oscillator stops; sub/osc/ext peripherals run
// - pending unmasked request releases halt at once
// - interrupt release resumes oscillator clock mode
// - reset release returns to normal mode
// - nmi or unmasked maskable request ends halt
// - lower priority in handler: release, keep pending
// - higher priority or nmi in handler: acknowledge
// - nmi release branches regardless of enable state
// - maskable release: disabled next, enabled branch/next
// - timer16 unit one runs on subclock watch interrupt
// - timer8 runs on external input or t16 compare
// - compact timer one runs only on osc/2048
// - watch timer runs only from selected subclock
module iohc_ctrl (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic osc_mode_req_i,
    input wire logic main_clock_ok_i,
    input wire logic halt_exec_i,
    input wire logic nmi_req_i,
    input wire logic mask_req_i,
    input wire logic [iohc_pkg::PRIO_W-1:0] mask_req_prio_i,
    input wire logic in_service_i,
    input wire logic [iohc_pkg::PRIO_W-1:0] service_prio_i,
    input wire logic interrupts_enabled_state_i,
    input wire logic subclock_used_i,
    input wire logic [1:0] timer16_unit_one_clk_sel_i,
    input wire logic [1:0] watch_timer_clk_sel_i,
    input wire logic [1:0] timer8_clk_sel_i [iohc_pkg::TIMER8_UNITS],
    input wire logic [1:0] compact_timer_one_clk_sel_i,
    output logic [1:0] mode_o,
    output logic halted_o,
    output logic cpu_clk_en_o,
    output logic main_osc_en_o,
    output logic internal_osc_en_o,
    output logic subclock_osc_en_o,
    output logic ram_write_block_o,
    output logic wake_o,
    output logic wake_ack_o,
    output logic [1:0] resume_action_o,
    output logic rom_correction_run_o,
    output logic first_16bit_timer_run_o,
    output logic timer16_unit_zero_run_o,
    output logic timer16_unit_one_run_o,
    output logic [iohc_pkg::TIMER8_UNITS-1:0] timer8_run_o,
    output logic compact_timer_zero_run_o,
    output logic compact_timer_one_run_o,
    output logic watch_timer_run_o,
    output logic watchdog_one_run_o,
    output logic intc_run_o
);
    // a request wakes if non-maskable or unmasked maskable
    function automatic logic wake_source(input logic nmi, input logic mreq);
        wake_source = nmi | mreq;
    endfunction

    // a unit stopped by halt unless its clock source survives it;
    // also used with keep tied low for units that always stop
    function automatic logic gate_run(input logic halt_now,
        input logic keep);
        gate_run = !halt_now | keep;
    endfunction

    // timer8 keeps counting on its external input, or on the timer16
    // unit one compare while that unit is itself still running
    function automatic logic t8_keep(input logic [1:0] sel,
        input logic sub, input logic t16_run);
        t8_keep = sel == iohc_pkg::TMR8_CLK_EXT_INPUT ||
            (sub && t16_run && sel == iohc_pkg::TMR8_CLK_T16_CMP);
    endfunction

    iohc_pkg::iohc_mode_t mode, next_mode;
    logic halted, next_halted;
    logic wake, next_wake;
    logic wake_ack, next_wake_ack;
    logic [1:0] resume, next_resume;
    logic ack_now;
    logic t16_one_run;
    logic [iohc_pkg::TIMER8_UNITS-1:0] t8_run;
    // handler context captured at halt entry
    logic svc_held, next_svc_held;
    logic [iohc_pkg::PRIO_W-1:0] svc_prio_held, next_svc_prio_held;
    logic halt_take;
    logic prio_higher;
    // clock sources that survive the halt
    logic t16_keep;
    logic watch_keep;
    logic cmpt_keep;

    // halt is taken only in osc run; a halt pulse in normal mode or
    // while already halted is ignored, so a stray second pulse cannot
    // overwrite the captured handler context
    assign halt_take = mode == iohc_pkg::IOHC_OSC_RUN && halt_exec_i;

    // service context of the handler that ran the halt; the cpu is
    // frozen while halted, so the copy taken on entry decides whether
    // a later request is acknowledged
    always_comb
    begin
        next_svc_held = svc_held;
        next_svc_prio_held = svc_prio_held;
        if (halt_take)
        begin
            next_svc_held = in_service_i;
            next_svc_prio_held = service_prio_i;
        end
    end

    // context registers; cleared by reset so a fresh halt after reset
    // is treated as outside any handler until captured
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            svc_held <= 1'b0;
            svc_prio_held <= '0;
        end
        else
        begin
            svc_held <= next_svc_held;
            svc_prio_held <= next_svc_prio_held;
        end
    end

    // lower level value is the more urgent request; equal levels
    // count as not higher
    assign prio_higher = mask_req_prio_i < svc_prio_held;

    // acknowledge when not nested, or nmi, or higher priority; an
    // equal or lower level only wakes the cpu and stays pending for
    // the interrupt controller to present again later
    always_comb
    begin
        ack_now = nmi_req_i;
        if (mask_req_i && (!svc_held || prio_higher))
        begin
            ack_now = 1'b1;
        end
    end

    // mode sequencing; reset always lands in normal mode
    always_comb
    begin
        next_mode = mode;
        next_halted = halted;
        next_wake = 1'b0;
        next_wake_ack = 1'b0;
        next_resume = resume;
        case (mode)
            iohc_pkg::IOHC_NORMAL:
            begin
                // halt pulses are refused in normal mode
                if (osc_mode_req_i)
                begin
                    next_mode = iohc_pkg::IOHC_OSC_RUN;
                end
            end
            iohc_pkg::IOHC_OSC_RUN:
            begin
                next_resume = iohc_pkg::RESUME_NONE;
                if (halt_exec_i)
                begin
                    // enter even with a request pending; leave next cycle
                    next_mode = iohc_pkg::IOHC_OSC_HALT;
                    next_halted = 1'b1;
                end
                // back to normal only once the main oscillator is stable
                else if (!osc_mode_req_i && main_clock_ok_i)
                begin
                    next_mode = iohc_pkg::IOHC_NORMAL;
                end
            end
            iohc_pkg::IOHC_OSC_HALT:
            begin
                if (wake_source(nmi_req_i, mask_req_i))
                begin
                    next_mode = iohc_pkg::IOHC_OSC_RUN;
                    next_halted = 1'b0;
                    next_wake = 1'b1;
                    // lower priority wakes but stays pending
                    next_wake_ack = ack_now;
                    // nmi always branches; a maskable one branches only
                    // when enabled and acknowledged, else next instruction
                    if (nmi_req_i)
                    begin
                        next_resume = iohc_pkg::RESUME_BRANCH;
                    end
                    else if (interrupts_enabled_state_i && ack_now)
                    begin
                        next_resume = iohc_pkg::RESUME_BRANCH;
                    end
                    else
                    begin
                        next_resume = iohc_pkg::RESUME_NEXT;
                    end
                end
            end
            // unused encoding recovers to normal mode
            default:
            begin
                next_mode = iohc_pkg::IOHC_NORMAL;
                next_halted = 1'b0;
            end
        endcase
    end

    // state registers; reset ends halt straight into normal mode, with no wake pulse
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            mode <= iohc_pkg::IOHC_NORMAL;
            halted <= 1'b0;
            wake <= 1'b0;
            wake_ack <= 1'b0;
            resume <= iohc_pkg::RESUME_NONE;
        end
        else
        begin
            mode <= next_mode;
            halted <= next_halted;
            wake <= next_wake;
            wake_ack <= next_wake_ack;
            resume <= next_resume;
        end
    end

    // which halt-surviving clock sources feed each gated unit; the
    // selections are read live, so they must be settled before halt
    always_comb
    begin
        t16_keep = subclock_used_i &&
            timer16_unit_one_clk_sel_i == iohc_pkg::TMR16_CLK_WATCH_INT &&
            watch_timer_clk_sel_i == iohc_pkg::WT_CLK_SUBCLOCK;
        watch_keep = subclock_used_i &&
            watch_timer_clk_sel_i == iohc_pkg::WT_CLK_SUBCLOCK;
        cmpt_keep = compact_timer_one_clk_sel_i ==
            iohc_pkg::CMPT_CLK_OSC_DIV2048;
    end

    // timer16 unit one counts the watch interrupt, which itself only
    // survives halt when the watch timer runs from the subclock
    assign t16_one_run = gate_run(halted, t16_keep);

    // each timer8 unit judged on its own count clock selection
    genvar g;
    generate
        for (g = 0; g < iohc_pkg::TIMER8_UNITS; g = g + 1)
        begin : g_t8
            assign t8_run[g] = gate_run(halted,
                t8_keep(timer8_clk_sel_i[g], subclock_used_i,
                t16_one_run));
        end
    endgenerate

    // every run enable below except intc_run_o is decoded from the halted register, so
    // every unit that halt stops does so on the same edge as the cpu clock and restarts
    // on the wake edge

    // mode and status, both straight from registers
    // so the cpu core sees no decode delay
    assign mode_o = mode;
    assign halted_o = halted;

    // halt gates the cpu clock and ram writes; the internal oscillator never stops
    assign cpu_clk_en_o = gate_run(halted, 1'b0);
    assign ram_write_block_o = halted;
    assign internal_osc_en_o = 1'b1;

    // main oscillator stops only while halted; osc run keeps it up so
    // that the return to normal mode need not wait for a restart
    assign main_osc_en_o = gate_run(halted, 1'b0);
    assign subclock_osc_en_o = subclock_used_i;
    assign intc_run_o = 1'b1;

    // wake-up report to the cpu core; wake and ack pulse one cycle,
    // resume holds until the next osc run cycle
    assign wake_o = wake;
    assign wake_ack_o = wake_ack;
    assign resume_action_o = resume;

    // units with no clock source that survives the halt; they pick
    // up from their held state on the wake edge
    assign rom_correction_run_o = gate_run(halted, 1'b0);
    assign first_16bit_timer_run_o = gate_run(halted, 1'b0);
    assign timer16_unit_zero_run_o = gate_run(halted, 1'b0);
    assign compact_timer_zero_run_o = gate_run(halted, 1'b0);
    assign watchdog_one_run_o = gate_run(halted, 1'b0);

    // units whose count clock may survive the halt; outside halt
    // all of them run
    assign timer16_unit_one_run_o = t16_one_run;
    assign timer8_run_o = t8_run;
    assign compact_timer_one_run_o = gate_run(halted, cmpt_keep);
    assign watch_timer_run_o = gate_run(halted, watch_keep);
endmodule

/* bench/iohc_ctrl_properties.sv */
// port assertions for the halt standby controller
// assumes it is bound onto iohc_ctrl, one clock domain
module iohc_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic halt_exec_i,
    input wire logic nmi_req_i,
    input wire logic mask_req_i,
    input wire logic [2:0] mask_req_prio_i,
    input wire logic in_service_i,
    input wire logic [2:0] service_prio_i,
    input wire logic interrupts_enabled_state_i,
    input wire logic subclock_used_i,
    input wire logic [1:0] watch_timer_clk_sel_i,
    input wire logic [1:0] compact_timer_one_clk_sel_i,
    input wire logic [1:0] mode_o,
    input wire logic halted_o,
    input wire logic cpu_clk_en_o,
    input wire logic main_osc_en_o,
    input wire logic ram_write_block_o,
    input wire logic wake_o,
    input wire logic wake_ack_o,
    input wire logic [1:0] resume_action_o,
    input wire logic watch_timer_run_o,
    input wire logic compact_timer_one_run_o,
    input wire logic watchdog_one_run_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // entry only from oscillator run mode
    a_halt_entry: assert property (mode_o == 2'h1 && halt_exec_i |=>
        halted_o && mode_o == 2'h2) else $error("halt not entered");
    a_cpu_gate: assert property (halted_o |->
        !cpu_clk_en_o && ram_write_block_o) else $error("cpu not gated");
    a_main_stop: assert property (halted_o |->
        !main_osc_en_o && !watchdog_one_run_o) else $error("clock runs");
    a_wake_nmi: assert property (halted_o && nmi_req_i |=>
        wake_o && wake_ack_o && resume_action_o == 2'h2 && mode_o == 2'h1)
        else $error("nmi wake wrong");
    // lower priority inside a handler wakes but stays pending
    a_wake_low: assert property (halted_o && mask_req_i && !nmi_req_i
        && in_service_i && mask_req_prio_i > service_prio_i |=>
        wake_o && !wake_ack_o) else $error("low prio acked");
    a_resume_di: assert property (halted_o && mask_req_i && !nmi_req_i
        && !interrupts_enabled_state_i |=> resume_action_o == 2'h1)
        else $error("resume not next");
    a_compact_gate: assert property (halted_o |->
        compact_timer_one_run_o == (compact_timer_one_clk_sel_i == 2'h3))
        else $error("compact gate wrong");
    a_watch_gate: assert property (halted_o |-> watch_timer_run_o ==
        (subclock_used_i && watch_timer_clk_sel_i == 2'h1))
        else $error("watch gate wrong");
endmodule
bind iohc_ctrl iohc_chk chk_u (.*);

/* bench/iohc_cpu_model.sv */
// cpu side model issuing the halt instruction
// assumes falling-edge drive and a 200 MHz clock
module iohc_cpu_model (
    input wire logic clk_i,
    output logic halt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int nops = 0;
    initial halt_o = 1'h0;
    // nop slots after a halt block the next instruction
    always @(negedge clk_i) if (nops > 0) nops--;
    task automatic halt();
        while (nops > 0) @(negedge clk_i);
        halt_o = 1'h1;
        @(negedge clk_i);
        halt_o = 1'h0;
        nops = 5;
    endtask
endmodule

/* bench/iohc_ctrl_bench.sv */
// self-checking bench for the halt standby controller
// assumes the cpu model drives halt_exec_i, bench drives the rest
module iohc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = '0, srst_i = '1, osc_mode_req_i = '0, main_clock_ok_i = '1;
    logic halt_exec_i, nmi_req_i = '0, mask_req_i = '0, in_service_i = '0;
    logic interrupts_enabled_state_i = '0, subclock_used_i = '0;
    logic [2:0] mask_req_prio_i = '0, service_prio_i = '0;
    logic [1:0] timer16_unit_one_clk_sel_i = '0, watch_timer_clk_sel_i = '0;
    logic [1:0] compact_timer_one_clk_sel_i = '0, mode_o, resume_action_o;
    logic [1:0] timer8_clk_sel_i [2] = '{2'h0, 2'h0};
    logic [1:0] timer8_run_o, e8;
    logic halted_o, cpu_clk_en_o, main_osc_en_o, internal_osc_en_o, wake_o;
    logic subclock_osc_en_o, ram_write_block_o, wake_ack_o, intc_run_o;
    logic rom_correction_run_o, first_16bit_timer_run_o, watch_timer_run_o;
    logic timer16_unit_zero_run_o, timer16_unit_one_run_o, watchdog_one_run_o;
    logic compact_timer_zero_run_o, compact_timer_one_run_o;
    bit kn, pend, ak, t16;
    int n_errors = 0, samples_checked = 0;
    iohc_ctrl dut_u (.*);
    iohc_cpu_model cpu_u (.clk_i(clk_i), .halt_o(halt_exec_i));
    initial forever #2.5 clk_i = !clk_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, far beyond the expected few hundred cycles
    initial
    begin
        #20000;
        n_errors++;
        give_verdict();
    end
    // random halt and wake rounds, then a reset out of halt
    initial
    begin
        void'($urandom(32'hf74d67b3));
        repeat (5) @(negedge clk_i);
        srst_i = '0;
        cpu_u.halt();
        chk(halted_o, 16'h0);
        repeat (40)
        begin
            osc_mode_req_i = '1;
            {subclock_used_i, timer16_unit_one_clk_sel_i, watch_timer_clk_sel_i,
                compact_timer_one_clk_sel_i, timer8_clk_sel_i[0],
                timer8_clk_sel_i[1]} = $urandom;
            {interrupts_enabled_state_i, in_service_i, mask_req_prio_i,
                service_prio_i, kn, pend} = $urandom;
            @(negedge clk_i);
            chk({wake_o, wake_ack_o, resume_action_o}, 16'h0);
            if (pend)
                {nmi_req_i, mask_req_i} = {kn, !kn};
            cpu_u.halt();
            // expected gating while halted
            t16 = subclock_used_i && timer16_unit_one_clk_sel_i == 2'h1
                && watch_timer_clk_sel_i == 2'h1;
            for (int i = 0; i < 2; i++)
                e8[i] = timer8_clk_sel_i[i] == 2'h1 || (subclock_used_i
                    && timer8_clk_sel_i[i] == 2'h2 && t16);
            chk({halted_o, mode_o, cpu_clk_en_o, main_osc_en_o,
                ram_write_block_o, internal_osc_en_o, timer16_unit_one_run_o,
                timer8_run_o, compact_timer_one_run_o, watch_timer_run_o},
                {5'h18, 2'h3, t16, e8, compact_timer_one_clk_sel_i == 2'h3,
                subclock_used_i && watch_timer_clk_sel_i == 2'h1});
            chk({rom_correction_run_o, first_16bit_timer_run_o,
                timer16_unit_zero_run_o, compact_timer_zero_run_o,
                watchdog_one_run_o, intc_run_o, subclock_osc_en_o},
                {5'h0, 1'b1, subclock_used_i});
            {nmi_req_i, mask_req_i} = {kn, !kn};
            ak = kn || !in_service_i || mask_req_prio_i < service_prio_i;
            @(negedge clk_i);
            chk({wake_o, wake_ack_o, mode_o, resume_action_o},
                {1'b1, ak, 2'h1, (kn || (interrupts_enabled_state_i && ak)) ?
                2'h2 : 2'h1});
            {nmi_req_i, mask_req_i} = '0;
        end
        cpu_u.halt();
        osc_mode_req_i = '0;
        srst_i = '1;
        @(negedge clk_i);
        srst_i = '0;
        @(negedge clk_i);
        chk({mode_o, halted_o, cpu_clk_en_o}, 16'h1);
        osc_mode_req_i = '1;
        @(negedge clk_i);
        chk(mode_o, 16'h1);
        osc_mode_req_i = '0;
        @(negedge clk_i);
        chk(mode_o, 16'h0);
        give_verdict();
    end
endmodule
